/* slave_arbiter_consts.vh */
// Constants for the per-slave master priority arbiter
`ifndef SLAVE_ARBITER_CONSTS_VH
`define SLAVE_ARBITER_CONSTS_VH

`define PRIO_BASE_OFFSET    8'h80
`define PRIO_STRIDE         8'h08
`define PRIO_RESET          32'h00000222
`define PRIO_FIELD_STRIDE   4
`define PRIO_FIELD_MASK     32'h33333333
`define WP_MODE_OFFSET      8'he4
`define WP_ENABLE_BIT       0
`define STATUS_OFFSET       8'he8
`define POOL_LOW            2'h0
`define POOL_MID_LOW        2'h1
`define POOL_MID_HIGH       2'h2
`define POOL_HIGH           2'h3

`endif

/* slave_port_pick.v */
// Grant selection for one slave port among eight masters
`timescale 1ns/1ps
`default_nettype none
`include "slave_arbiter_consts.vh"

module slave_port_pick #(
    parameter MASTERS = 8
) (
    // Requests and their programmed levels
    input  wire [MASTERS-1:0]   request,
    input  wire [31:0]          priority_word,
    input  wire [2:0]           last_grant,
    // Chosen master
    output reg                  grant_valid,
    output reg  [2:0]           grant_index
);

    reg     [1:0]   level;
    reg     [1:0]   best_level;
    reg     [2:0]   idx;
    reg             found;
    integer         m;
    integer         k;

    // Highest level among requesters sets the pool
    always @* begin
        best_level = `POOL_LOW;
        found = 1'b0;
        level = `POOL_LOW;
        for (m = 0; m < MASTERS; m = m + 1) begin
            level = priority_word[m*`PRIO_FIELD_STRIDE +: 2];
            if (request[m] && (!found || level > best_level)) begin
                best_level = level;
                found = 1'b1;
            end
        end
    end

    // Outer pools rotate after the last grant; middle pools take lowest index
    always @* begin
        grant_valid = 1'b0;
        grant_index = 3'h0;
        idx = 3'h0;
        for (k = 0; k < MASTERS; k = k + 1) begin
            if (best_level == `POOL_LOW || best_level == `POOL_HIGH) begin
                // Three-bit sum wraps past the top index on purpose
                idx = last_grant + k[2:0] + 3'h1;
            end else begin
                idx = k[2:0];
            end
            if (!grant_valid && request[idx] &&
                priority_word[idx*`PRIO_FIELD_STRIDE +: 2] == best_level) begin
                grant_valid = 1'b1;
                grant_index = idx;
            end
        end
    end

endmodule // slave_port_pick
`default_nettype wire

/* slave_port_priority_arbiter.v */
// Per-slave master priority registers and arbitration for a bus matrix
// Contract
// - Each slave holds a 2-bit priority per master; higher value wins.
// - Master fields sit at bits 0:1, 4:5 ... 28:29, masters zero to seven.
// - Masters with equal value form one pool; pools ordered by value.
// - Lowest and highest pools grant round-robin.
// - Middle pools grant by fixed order.
// - Priority register writes only taken while write protect is clear.
// - Slave x register sits at 0x80 plus x times 0x08.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "slave_arbiter_consts.vh"

// Operation notes
//   Priority word of slave port x at 0x80 + 8*x; each master owns a
//   nibble, and only the two low bits of each nibble are stored.
//   Write-protect mode register at 0xe4, bit 0; it gates the priority
//   words only, and a blocked write leaves no trace anywhere.
//   Grant status at 0xe8, one bit per slave port, the live grant_valid.
//   The highest level among requesters picks the pool. Levels 0 and 3
//   rotate from the last granted master; levels 1 and 2 give the lowest
//   master index, so a busy low master can starve a higher one there.
//   Grants are registered: they answer the requests of the cycle before.

module slave_port_priority_arbiter #(
    parameter SLAVES  = 4,
    parameter MASTERS = 8
) (
    // Clock and reset
    input  wire                 clock,
    input  wire                 arst_n,
    // Register port
    input  wire [7:0]           address,
    input  wire [31:0]          write_data,
    input  wire                 write_strobe,
    input  wire                 read_strobe,
    output reg  [31:0]          read_data,
    // Requests per slave, master-major within each slave
    input  wire [SLAVES*MASTERS-1:0] request,
    // Grants per slave
    output reg  [SLAVES-1:0]    grant_valid,
    output reg  [SLAVES*3-1:0]  grant_index
);

    // Geometry of one priority word and one grant index
    localparam WORD_BITS  = 32;
    localparam FIELD_BITS = 2;
    localparam INDEX_BITS = 3;

    // Address decode of the fixed registers and the priority slots
    wire                            hit_mode;
    wire                            hit_status;
    wire    [SLAVES-1:0]            hit_prio;
    wire                            any_prio_hit;

    // Write side; the protect bit guards the priority slots only
    wire                            write_mode;
    wire    [SLAVES-1:0]            write_prio;
    wire    [WORD_BITS-1:0]         clean_word;
    reg                             write_protect_enable;

    // Stored priority words, flattened so that loops can index them
    wire    [SLAVES*WORD_BITS-1:0]  prio_words;

    // Read side
    wire    [SLAVES*WORD_BITS-1:0]  read_parts;
    wire    [WORD_BITS-1:0]         mode_word;
    wire    [WORD_BITS-1:0]         status_word;
    reg     [WORD_BITS-1:0]         next_read;
    integer                         r;

    // Arbitration
    wire    [SLAVES-1:0]            next_valid;
    wire    [SLAVES*INDEX_BITS-1:0] next_index;
    genvar                          g;
    genvar                          f;

    // Fixed registers decode on the whole byte address
    assign hit_mode     = (address == `WP_MODE_OFFSET);
    assign hit_status   = (address == `STATUS_OFFSET);
    assign any_prio_hit = |hit_prio;

    // Cleaned write word: each master keeps its two field bits only
    generate
        for (f = 0; f < MASTERS; f = f + 1) begin : field
            assign clean_word[f*`PRIO_FIELD_STRIDE +: `PRIO_FIELD_STRIDE] =
                {{(`PRIO_FIELD_STRIDE-FIELD_BITS){1'b0}},
                 write_data[f*`PRIO_FIELD_STRIDE +: FIELD_BITS]};
        end
    endgenerate

    // Write-protect mode bit; the mode register itself is never locked
    assign write_mode = write_strobe && hit_mode;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            write_protect_enable <= 1'b0;
        end else if (write_mode) begin
            write_protect_enable <= write_data[`WP_ENABLE_BIT];
        end
    end

    // One priority slot per slave port
    generate
        for (g = 0; g < SLAVES; g = g + 1) begin : slot
            wire    [WORD_BITS-1:0]     slot_address;
            reg     [WORD_BITS-1:0]     slave_master_priority;

            // Only the low byte is decoded, so SLAVES must stay small
            // enough for the slots to keep clear of the fixed registers
            assign slot_address =
                `PRIO_BASE_OFFSET + g * `PRIO_STRIDE;
            assign hit_prio[g] = (address == slot_address[7:0]);

            // A protected write is dropped with no indication to the master
            assign write_prio[g] = write_strobe && hit_prio[g] &&
                                   !write_protect_enable;

            // Priority word; field bits only, the gaps always read zero
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    slave_master_priority <= `PRIO_RESET;
                end else if (write_prio[g]) begin
                    slave_master_priority <= clean_word;
                end
            end

            // Flat views for the chooser and the read mux
            assign prio_words[g*WORD_BITS +: WORD_BITS] =
                slave_master_priority;
            assign read_parts[g*WORD_BITS +: WORD_BITS] =
                hit_prio[g] ? slave_master_priority : {WORD_BITS{1'b0}};
        end
    endgenerate

    // Mode and status words as software sees them
    assign mode_word   = {{(WORD_BITS-1){1'b0}}, write_protect_enable};
    assign status_word = {{(WORD_BITS-SLAVES){1'b0}}, grant_valid};

    // Read decode; at most one source is selected, unmapped reads zero
    always @* begin
        next_read = {WORD_BITS{1'b0}};
        if (hit_mode) begin
            next_read = mode_word;
        end else if (hit_status) begin
            next_read = status_word;
        end else if (any_prio_hit) begin
            for (r = 0; r < SLAVES; r = r + 1) begin
                next_read = next_read | read_parts[r*WORD_BITS +: WORD_BITS];
            end
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            read_data <= {WORD_BITS{1'b0}};
        end else if (read_strobe) begin
            read_data <= next_read;
        end else begin
            read_data <= {WORD_BITS{1'b0}};
        end
    end

    // One chooser and one round-robin pointer per slave port
    generate
        for (g = 0; g < SLAVES; g = g + 1) begin : port
            reg     [INDEX_BITS-1:0]    last_grant;

            slave_port_pick #(
                .MASTERS        (MASTERS)
            ) pick (
                .request        (request[g*MASTERS +: MASTERS]),
                .priority_word  (prio_words[g*WORD_BITS +: WORD_BITS]),
                .last_grant     (last_grant),
                .grant_valid    (next_valid[g]),
                .grant_index    (next_index[g*INDEX_BITS +: INDEX_BITS])
            );

            // Pointer starts at the top index so master zero leads the
            // first rotation; it follows every grant, whatever the pool
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    last_grant <= {INDEX_BITS{1'b1}};
                end else if (next_valid[g]) begin
                    last_grant <= next_index[g*INDEX_BITS +: INDEX_BITS];
                end
            end
        end
    endgenerate

    // Grants registered so every output leaves a flip-flop
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            grant_valid <= {SLAVES{1'b0}};
            grant_index <= {(SLAVES*INDEX_BITS){1'b0}};
        end else begin
            grant_valid <= next_valid;
            grant_index <= next_index;
        end
    end

endmodule // slave_port_priority_arbiter
`default_nettype wire

/* master_requesters.sv */
// Bus masters holding their slave requests as levels
`timescale 1ns/1ps
`default_nettype none
module master_requesters (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [31:0] want,
    output var  logic [31:0] request
);
    // Requests change only after an edge, as real masters do
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n) request <= '0;
        else request <= want;
endmodule // master_requesters
`default_nettype wire

/* slave_port_priority_arbiter_asserts.sv */
// Port checker for the slave priority arbiter
`timescale 1ns/1ps
`default_nettype none
module arb_checker #(parameter SLAVES = 4, parameter MASTERS = 8) (
    input wire logic clock, arst_n, write_strobe, read_strobe,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data, read_data,
    input wire logic [SLAVES*MASTERS-1:0] request,
    input wire logic [SLAVES-1:0] grant_valid,
    input wire logic [SLAVES*3-1:0] grant_index
);
    // One domain, so clock and reset are shared
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_RD_IDLE: assert property (!$past(read_strobe) |-> read_data == 0)
        else $error("read data not zero outside a read");
    AST_RD_MASK: assert property ($past(read_strobe) &&
        $past(address) == 8'h80 |-> (read_data & 32'hcccccccc) == 0)
        else $error("priority word has bits outside fields");
    AST_UNMAP: assert property ($past(read_strobe) &&
        $past(address) == 8'h40 |-> read_data == 0)
        else $error("unmapped read not zero");
    AST_GV0: assert property (grant_valid[0] == $past(|request[7:0]))
        else $error("slave 0 grant without request");
    AST_GV2: assert property ($past(request[23:16]) == 0 |-> !grant_valid[2])
        else $error("slave 2 grant without request");
    AST_GI0: assert property (grant_valid[0] |->
        ($past(request[7:0]) >> grant_index[2:0]) & 8'h01)
        else $error("slave 0 granted an idle master");
    AST_GI1: assert property (grant_valid[1] |->
        ($past(request[15:8]) >> grant_index[5:3]) & 8'h01)
        else $error("slave 1 granted an idle master");
endmodule // arb_checker
bind slave_port_priority_arbiter arb_checker #(.SLAVES(SLAVES),
    .MASTERS(MASTERS)) u_chk (.clock(clock), .arst_n(arst_n),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .address(address), .write_data(write_data), .read_data(read_data),
    .request(request), .grant_valid(grant_valid),
    .grant_index(grant_index));
`default_nettype wire

/* test_slave_port_priority_arbiter.sv */
// Testbench for the slave priority arbiter
`timescale 1ns/1ps
`default_nettype none
module test_slave_port_priority_arbiter;
    logic        clock = 0, arst_n = 0, write_strobe = 0, read_strobe = 0;
    logic [7:0]  address = 0;
    logic [31:0] write_data = 0, read_data, want = 0, request;
    logic [3:0]  grant_valid;
    logic [11:0] grant_index;
    int          failures = 0, n_compared = 0;
    always #5 clock = ~clock;
    slave_port_priority_arbiter i_dut (.clock(clock), .arst_n(arst_n),
        .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .request(request),
        .grant_valid(grant_valid), .grant_index(grant_index));
    master_requesters i_masters (.clock(clock), .arst_n(arst_n),
        .want(want), .request(request));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 cmp(read_data, exp);
    endtask
    // Model registers the request, grant follows one cycle later
    task automatic pick(input logic [31:0] w, input logic [2:0] m);
        @(posedge clock);
        want <= w;
        repeat (2) @(posedge clock);
        #1 cmp({grant_valid[0], grant_index[2:0]}, {1'b1, m});
    endtask
    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    initial begin
        #20us;
        failures++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        for (int s = 0; s < 4; s++) rd(8'(8'h80 + 8 * s), 32'h222);
        rd(8'h40, 32'h0);
        wr(8'h80, 32'hffffffff);
        rd(8'h80, 32'h33333333);
        $display("register test done");
        wr(8'h80, 32'h222);
        pick(32'h6, 3'd1);
        pick(32'h12, 3'd1);
        wr(8'h80, 32'h00300222);
        pick(32'h22, 3'd5);
        $display("priority test done");
        // Pointer sits on master 5, so the pool of 4 and 5 starts at 4
        wr(8'h80, 32'h00330000);
        pick(32'h30, 3'd4);
        @(posedge clock);
        #1 cmp(grant_index[2:0], 3'd5);
        @(posedge clock);
        #1 cmp(grant_index[2:0], 3'd4);
        @(posedge clock);
        want <= 32'h0;
        $display("round robin test done");
        // Slave 3: masters 2 and 3 at level 1, master 6 at level 0
        wr(8'h98, 32'h00001100);
        rd(8'h98, 32'h00001100);
        @(posedge clock);
        want <= 32'h4c000000;
        repeat (2) @(posedge clock);
        #1 cmp({grant_valid, grant_index[11:9]}, {4'h8, 3'd2});
        rd(8'he8, 32'h8);
        cmp(grant_index[11:9], 3'd2);
        @(posedge clock);
        want <= 32'h0;
        $display("slave port test done");
        wr(8'he4, 32'h1);
        rd(8'he4, 32'h1);
        wr(8'h80, 32'h0);
        rd(8'h80, 32'h00330000);
        wr(8'he4, 32'h0);
        wr(8'h80, 32'h0);
        rd(8'h80, 32'h0);
        $display("protect test done");
        stop_test;
    end
endmodule // test_slave_port_priority_arbiter
`default_nettype wire
